// ---- src/failsafe_defines.vh ----
// Timing and encoding constants for the fail output and heartbeat monitor
`ifndef FAILSAFE_DEFINES_VH
`define FAILSAFE_DEFINES_VH
`define CLK_PERIOD_NS        10
`define BLINK_PERIOD_NS      800000000
`define BLINK_HALF_CYC       (`BLINK_PERIOD_NS / 2 / `CLK_PERIOD_NS)
`define DIM_PERIOD_NS        10000000
`define DIM_PERIOD_CYC       (`DIM_PERIOD_NS / `CLK_PERIOD_NS)
`define DIM_ON_PERCENT       20
`define DIM_ON_CYC           (`DIM_PERIOD_CYC * `DIM_ON_PERCENT / 100)
`define HB_WINDOW_NS         240000
`define HB_WINDOW_CYC        (`HB_WINDOW_NS / `CLK_PERIOD_NS)
`define HB_FILTER_NS         1500
`define HB_FILTER_CYC        (`HB_FILTER_NS / `CLK_PERIOD_NS)
`define TEST_FILTER_NS       16000
`define TEST_FILTER_CYC      (`TEST_FILTER_NS / `CLK_PERIOD_NS)
`define MODE_INIT            3'h0
`define MODE_NORMAL          3'h1
`define MODE_STOP            3'h2
`define MODE_SLEEP           3'h3
`define MODE_RESTART         3'h4
`define MODE_FAILSAFE        3'h5
`endif

// ---- src/failsafe_output_input_monitor.v ----
// Fail output driver and heartbeat input monitor
// Operation
// - Each fail output is a low-side switch pulling its pin low when active.
// - Any failure activates the outputs and sets the fail-out-active flag.
// - Failures: watchdog strikes, thermal level two, buck rail short, reset clamped high.
// - A strike select bit picks one or two consecutive watchdog failures.
// - Outputs release only with no failure present and the flag cleared.
// - After watchdog failure, release waits for good trigger and cleared flags.
// - Every failure activates the outputs, not only fail-safe mode ones.
// - All three outputs switch on together at activation.
// - Static output stays low throughout activation.
// - Blink output toggles at 1.25 Hz, 50 percent duty, while active.
// - Dim output gives 100 Hz PWM, 20 percent duty, while active.
// - Pull-ups enabled per mode: static, blink with disable low, dim init.
// - The blink pin also serves as heartbeat input.
// - A rising heartbeat edge is needed within each 240 us window.
// - Monitoring on after power-on, off when the disable bit is 1.
// - Missing heartbeat sets its flag and drives static and dim outputs.
// - The heartbeat flag ignores clears until a new rising edge arrives.
// - Heartbeat monitoring runs in normal mode only.
// - Heartbeat input passes a glitch filter of at most 1.5 us.
// - The dim pin as test select gets a 16 us input filter.
// - A watchdog reset enters restart mode and sets watchdog failure flags.
// - Reset asserted while pin still senses high latches the clamp flag.
`timescale 1ns/100ps
`include "failsafe_defines.vh"
module failsafe_output_input_monitor
#(
  parameter BLINK_HALF = `BLINK_HALF_CYC,
  parameter DIM_PERIOD = `DIM_PERIOD_CYC,
  parameter DIM_ON     = `DIM_ON_CYC,
  parameter HB_WINDOW  = `HB_WINDOW_CYC,
  parameter TEST_FILT  = `TEST_FILTER_CYC
)
(
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire [2:0] operating_mode,
  input  wire       watchdog_strike_select,
  input  wire       failsafe_in_disable,
  input  wire       watchdog_fail_event,
  input  wire       watchdog_trigger_ok,
  input  wire       watchdog_flags_clear,
  input  wire       thermal_shutdown_level2,
  input  wire       buck_supply_rail_short,
  input  wire       reset_asserted,
  input  wire       reset_output_sense,
  input  wire       reset_clamp_clear,
  input  wire       fail_out_clear,
  input  wire       heartbeat_clear,
  input  wire       heartbeat_input,
  input  wire       test_select_in,
  output reg        watchdog_failure_flags,
  output reg        reset_clamp_high_flag,
  output reg        fail_out_active_flag,
  output reg        heartbeat_missing_flag,
  output reg        restart_request,
  output reg        test_mode_select,
  output reg        fail_out_static_oe_n,
  output reg        fail_out_blink_oe_n,
  output reg        fail_out_dim_oe_n,
  output wire       fail_out_static_pullup,
  output wire       fail_out_blink_pullup,
  output wire       fail_out_dim_pullup
);

  // Synchroniser stages count toward the filter bound, so the counter is shorter
  localparam [31:0] HB_FILT = `HB_FILTER_CYC - 3;

  reg  [1:0]  strike_cnt_ff;
  reg         watchdog_failure_flags_latched_ff;
  reg         wd_trig_seen_ff;
  reg  [2:0]  hb_sync_ff;
  reg  [31:0] hb_filt_cnt_ff;
  reg         hb_filt_ff;
  reg         hb_prev_ff;
  reg         hb_rise_seen_ff;
  reg  [31:0] hb_win_ff;
  reg  [2:0]  ts_sync_ff;
  reg  [31:0] ts_cnt_ff;
  reg  [31:0] blink_cnt_ff;
  reg         blink_phase_ff;
  reg  [31:0] dim_cnt_ff;
  reg         fo_run_ff;

  wire normal_mode = (operating_mode == `MODE_NORMAL);
  wire init_mode   = (operating_mode == `MODE_INIT);
  wire hb_enabled  = normal_mode && !failsafe_in_disable;
  wire hb_rise     = hb_filt_ff && !hb_prev_ff;
  wire hb_timeout  = hb_enabled && (hb_win_ff >= HB_WINDOW - 1);
  wire clamp_event = reset_asserted && reset_output_sense;
  // Strike threshold: one or two consecutive watchdog failures
  wire wd_strike   = watchdog_fail_event &&
                     ((strike_cnt_ff != 2'h0) || !watchdog_strike_select);
  // Any still-present condition blocks release of the outputs
  wire fail_present = watchdog_failure_flags_latched_ff || thermal_shutdown_level2 ||
                      buck_supply_rail_short || reset_clamp_high_flag;
  wire fail_set     = wd_strike || thermal_shutdown_level2 || buck_supply_rail_short ||
                      clamp_event || reset_clamp_high_flag;

  // Pull-ups follow operating mode; the blink pull-up is also gated off by the disable bit
  assign fail_out_static_pullup = init_mode || normal_mode;
  assign fail_out_blink_pullup  = (init_mode || normal_mode) && !failsafe_in_disable;
  assign fail_out_dim_pullup    = init_mode;

  // Watchdog strike counting and failure flags
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strike_cnt_ff          <= 2'h0;
      watchdog_failure_flags_latched_ff     <= 1'b0;
      wd_trig_seen_ff        <= 1'b0;
      watchdog_failure_flags <= 1'b0;
      restart_request        <= 1'b0;
    end
    else
    begin
      restart_request <= watchdog_fail_event;
      if (watchdog_fail_event)
      begin
        watchdog_failure_flags <= 1'b1;
        if (strike_cnt_ff != 2'h3)
          strike_cnt_ff <= strike_cnt_ff + 2'h1;
      end
      else
      begin
        // Trigger and software clear are independent, either may come alone
        if (watchdog_trigger_ok)
          strike_cnt_ff <= 2'h0;                              // Good trigger breaks the run
        if (watchdog_flags_clear)
          watchdog_failure_flags <= 1'b0;
      end
      // Set wins; release needs a good trigger since the strike and cleared flags,
      // in either order, so software need not sequence the two
      if (wd_strike)
      begin
        watchdog_failure_flags_latched_ff <= 1'b1;
        wd_trig_seen_ff    <= 1'b0;
      end
      else
      begin
        if (watchdog_trigger_ok)
          wd_trig_seen_ff <= 1'b1;
        if ((watchdog_trigger_ok || wd_trig_seen_ff) && !watchdog_failure_flags)
          watchdog_failure_flags_latched_ff <= 1'b0;
      end
    end
  end

  // Reset clamp flag, set wins over clear
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      reset_clamp_high_flag <= 1'b0;
    else if (clamp_event)
      reset_clamp_high_flag <= 1'b1;
    else if (reset_clamp_clear)
      reset_clamp_high_flag <= 1'b0;
  end

  // Fail-out flag: release only with nothing present and software clear
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      fail_out_active_flag <= 1'b0;
    else if (fail_set)
      fail_out_active_flag <= 1'b1;
    else if (fail_out_clear && !fail_present)
      fail_out_active_flag <= 1'b0;
  end

  // Heartbeat pin: three-stage synchroniser, then glitch filter
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hb_sync_ff     <= 3'h7;                                 // Idle high like the pulled-up pin
      hb_filt_cnt_ff <= 32'h0;
      hb_filt_ff     <= 1'b1;                                 // No false rise after reset
      hb_prev_ff     <= 1'b1;
    end
    else
    begin
      hb_sync_ff <= {hb_sync_ff[1:0], heartbeat_input};
      hb_prev_ff <= hb_filt_ff;
      if (hb_sync_ff[2] != hb_sync_ff[1] || hb_sync_ff[2] == hb_filt_ff)
        hb_filt_cnt_ff <= 32'h0;
      else if (hb_filt_cnt_ff >= HB_FILT - 1)
      begin
        hb_filt_ff     <= hb_sync_ff[2];
        hb_filt_cnt_ff <= 32'h0;
      end
      else
        hb_filt_cnt_ff <= hb_filt_cnt_ff + 32'h1;
    end
  end

  // Heartbeat window and missing flag; flag clears only after a new rise
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hb_win_ff              <= 32'h0;
      heartbeat_missing_flag <= 1'b0;
      hb_rise_seen_ff        <= 1'b0;
    end
    else
    begin
      if (!hb_enabled || hb_rise || hb_timeout)
        hb_win_ff <= 32'h0;
      else
        hb_win_ff <= hb_win_ff + 32'h1;
      if (hb_timeout && !hb_rise)
      begin
        heartbeat_missing_flag <= 1'b1;
        hb_rise_seen_ff        <= 1'b0;
      end
      else
      begin
        // A clear is honoured once any rise has followed the loss
        if (hb_rise)
          hb_rise_seen_ff <= 1'b1;
        if (heartbeat_clear && (hb_rise || hb_rise_seen_ff))
          heartbeat_missing_flag <= 1'b0;
      end
    end
  end

  // Test select sampled on the dim pin through a long filter
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ts_sync_ff       <= 3'h0;
      ts_cnt_ff        <= 32'h0;
      test_mode_select <= 1'b0;
    end
    else
    begin
      ts_sync_ff <= {ts_sync_ff[1:0], test_select_in};
      if (ts_sync_ff[2] != ts_sync_ff[1] || ts_sync_ff[2] == test_mode_select)
        ts_cnt_ff <= 32'h0;
      else if (ts_cnt_ff >= TEST_FILT - 1)
      begin
        test_mode_select <= ts_sync_ff[2];
        ts_cnt_ff        <= 32'h0;
      end
      else
        ts_cnt_ff <= ts_cnt_ff + 32'h1;
    end
  end

  // Blink and dim timebases restart at a fixed phase on activation
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fo_run_ff      <= 1'b0;
      blink_cnt_ff   <= 32'h0;
      blink_phase_ff <= 1'b0;
      dim_cnt_ff     <= 32'h0;
    end
    else
    begin
      fo_run_ff <= fail_out_active_flag || heartbeat_missing_flag;
      if (!fo_run_ff)
      begin
        blink_cnt_ff   <= 32'h0;
        blink_phase_ff <= 1'b0;
        dim_cnt_ff     <= 32'h0;
      end
      else
      begin
        if (blink_cnt_ff >= BLINK_HALF - 1)
        begin
          blink_cnt_ff   <= 32'h0;
          blink_phase_ff <= !blink_phase_ff;
        end
        else
          blink_cnt_ff <= blink_cnt_ff + 32'h1;
        if (dim_cnt_ff >= DIM_PERIOD - 1)
          dim_cnt_ff <= 32'h0;
        else
          dim_cnt_ff <= dim_cnt_ff + 32'h1;
      end
    end
  end

  // Low-side switches: enable low means pin pulled low
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fail_out_static_oe_n <= 1'b1;
      fail_out_blink_oe_n  <= 1'b1;
      fail_out_dim_oe_n    <= 1'b1;
    end
    else
    begin
      // Heartbeat loss leaves blink pin free so the heartbeat can still be seen
      fail_out_static_oe_n <= !fo_run_ff;
      fail_out_blink_oe_n  <= !(fail_out_active_flag && fo_run_ff && !blink_phase_ff);
      fail_out_dim_oe_n    <= !(fo_run_ff && (dim_cnt_ff < DIM_ON));
    end
  end

endmodule

// ---- testbench/failsafe_output_input_monitor_properties.sv ----
// Port checker for the fail outputs and heartbeat monitor
`timescale 1ns/100ps
`include "failsafe_defines.vh"
module failsafe_port_checker
#(
  parameter DIM_ON = 2
)
(
  input wire       ref_clk,
  input wire       reset_n,
  input wire [2:0] operating_mode,
  input wire       failsafe_in_disable,
  input wire       watchdog_fail_event,
  input wire       thermal_shutdown_level2,
  input wire       buck_supply_rail_short,
  input wire       watchdog_failure_flags,
  input wire       fail_out_active_flag,
  input wire       restart_request,
  input wire       fail_out_static_oe_n,
  input wire       fail_out_blink_oe_n,
  input wire       fail_out_dim_oe_n,
  input wire       fail_out_static_pullup,
  input wire       fail_out_blink_pullup,
  input wire       fail_out_dim_pullup
);
  reg  [31:0] dim_low_ff;
  wire        fault = thermal_shutdown_level2 || buck_supply_rail_short;
  wire        run_mode = operating_mode == `MODE_INIT || operating_mode == `MODE_NORMAL;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Run length of the dim low phase, so the duty bound holds whatever the period
  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      dim_low_ff <= 32'h0;
    else
      dim_low_ff <= fail_out_dim_oe_n ? 32'h0 : dim_low_ff + 32'h1;
  // A fresh failure, and the three switches all pulling
  sequence fresh_fault;
    fault && !fail_out_active_flag;
  endsequence
  sequence all_low;
    !fail_out_static_oe_n && !fail_out_blink_oe_n && !fail_out_dim_oe_n;
  endsequence
  set_flag_a: assert property (fresh_fault |=> fail_out_active_flag)
    else $error("fail flag not set");
  all_on_a: assert property (fresh_fault |=> ##2 all_low)
    else $error("outputs not on together");
  hold_flag_a: assert property (fail_out_active_flag && fault |=> fail_out_active_flag)
    else $error("flag cleared with fault present");
  wd_flag_a: assert property (watchdog_fail_event |=> watchdog_failure_flags)
    else $error("watchdog flag not set");
  restart_pulse_a: assert property (watchdog_fail_event |=> restart_request ##1 !restart_request)
    else $error("restart pulse wrong");
  static_pullup_a: assert property (fail_out_static_pullup == run_mode)
    else $error("static pullup wrong");
  blink_pullup_a: assert property (fail_out_blink_pullup == (run_mode && !failsafe_in_disable))
    else $error("blink pullup wrong");
  dim_pullup_a: assert property (fail_out_dim_pullup == (operating_mode == `MODE_INIT))
    else $error("dim pullup wrong");
  dim_duty_a: assert property (dim_low_ff <= DIM_ON)
    else $error("dim low phase too long");
endmodule
bind failsafe_output_input_monitor failsafe_port_checker #(.DIM_ON(DIM_ON)) u_port_checker (.ref_clk, .reset_n,
  .operating_mode, .failsafe_in_disable, .watchdog_fail_event, .thermal_shutdown_level2, .buck_supply_rail_short,
  .watchdog_failure_flags, .fail_out_active_flag, .restart_request, .fail_out_static_oe_n, .fail_out_blink_oe_n,
  .fail_out_dim_oe_n, .fail_out_static_pullup, .fail_out_blink_pullup, .fail_out_dim_pullup);

// ---- testbench/heartbeat_source.sv ----
// Microcontroller heartbeat driving the shared blink pin
`timescale 1ns/100ps
module heartbeat_source
#(
  parameter HALF = 200
)
(
  input  wire ref_clk,
  input  wire run,
  output reg  level = 1'b0
);
  integer cnt_ff = 0;
  // Square wave while running; stalled firmware leaves the line low
  always @(posedge ref_clk)
    if (!run)
    begin
      cnt_ff <= 0;
      level  <= 1'b0;
    end
    else if (cnt_ff == HALF - 1)
    begin
      cnt_ff <= 0;
      level  <= ~level;
    end
    else
      cnt_ff <= cnt_ff + 1;
endmodule

// ---- testbench/failsafe_output_input_monitor_test.sv ----
// Self-checking bench for the fail outputs and heartbeat monitor
`timescale 1ns/100ps
`include "failsafe_defines.vh"
module failsafe_output_input_monitor_test;
  localparam BH = 20, DP = 10, DO = 2, HW = 600, TF = 8;
  localparam [5:0] EV = 6'h01, OK = 6'h02, WC = 6'h04, CC = 6'h08, FC = 6'h10, HC = 6'h20;
  logic       ref_clk = 1'b0, reset_n = 1'b0, sel = 1'b0, dis = 1'b1, test_in = 1'b0, hb_run = 1'b0;
  logic       glitch = 1'b0;
  logic [2:0] mode = `MODE_NORMAL;
  logic [3:0] cause = 4'h0;
  logic [5:0] pls = 6'h0;
  wire        wdf, clf, fof, hbf, rrq, tsel, st_n, bl_n, dm_n, pu_st, pu_bl, pu_dm, hb_lvl;
  wire        hb_pin = bl_n ? (hb_lvl | glitch) : 1'b0; // Pin reads low while the blink switch pulls it
  integer     n_errors = 0, checks_done = 0;
  // Pulse and cause inputs are packed; one task can strobe any of the pulse inputs
  failsafe_output_input_monitor #(.BLINK_HALF(BH), .DIM_PERIOD(DP), .DIM_ON(DO), .HB_WINDOW(HW), .TEST_FILT(TF))
  DUT (.ref_clk, .reset_n, .operating_mode(mode), .watchdog_strike_select(sel), .failsafe_in_disable(dis),
    .watchdog_fail_event(pls[0]), .watchdog_trigger_ok(pls[1]), .watchdog_flags_clear(pls[2]),
    .thermal_shutdown_level2(cause[3]), .buck_supply_rail_short(cause[2]), .reset_asserted(cause[1]),
    .reset_output_sense(cause[0]), .reset_clamp_clear(pls[3]), .fail_out_clear(pls[4]), .heartbeat_clear(pls[5]),
    .heartbeat_input(hb_pin), .test_select_in(test_in), .watchdog_failure_flags(wdf), .reset_clamp_high_flag(clf),
    .fail_out_active_flag(fof), .heartbeat_missing_flag(hbf), .restart_request(rrq), .test_mode_select(tsel),
    .fail_out_static_oe_n(st_n), .fail_out_blink_oe_n(bl_n), .fail_out_dim_oe_n(dm_n),
    .fail_out_static_pullup(pu_st), .fail_out_blink_pullup(pu_bl), .fail_out_dim_pullup(pu_dm));
  heartbeat_source #(.HALF(200)) mcu (.ref_clk, .run(hb_run), .level(hb_lvl));
  always #5 ref_clk = ~ref_clk;
  task cyc(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // An idle edge first, so two calls never touch pls in one time step
  task pulse(input logic [5:0] m);
    @(posedge ref_clk);
    #1 pls = m;
    cyc(1);
    pls = 6'h0;
  endtask
  // Bounded wait on the heartbeat flag; running out ends the run
  task wait_hb(input logic v, input integer lim);
    integer k;
    for (k = 0; hbf !== v; k++)
    begin
      if (k == lim)
      begin
        n_errors++;
        summarize;
      end
      cyc(1);
    end
  endtask
  task t_pullups;
    integer m;
    for (m = 0; m < 12; m++)
    begin
      mode = 3'(m / 2);
      dis = m[0];
      cyc(1);
      chk("static pullup", mode <= `MODE_NORMAL, pu_st);
      chk("blink pullup", mode <= `MODE_NORMAL && !dis, pu_bl);
      chk("dim pullup", mode == `MODE_INIT, pu_dm);
    end
    mode = `MODE_NORMAL;
    dis = 1'b1;
  endtask
  // Thermal, rail short and clamped reset each raise, hold and release
  task t_causes;
    integer i, lo_b, lo_d;
    for (i = 0; i < 3; i++)
    begin
      cause = (i == 2) ? 4'h3 : 4'h8 >> i;
      cyc(3);
      lo_b = 0;
      lo_d = 0;
      repeat (2 * BH)
      begin
        lo_b += !bl_n;
        lo_d += !dm_n;
        cyc(1);
      end
      chk("active flag", 1'b1, fof);
      chk("clamp flag", i == 2, clf);
      chk("static out", 1'b0, st_n);
      chk("blink duty", 1'b1, lo_b == BH);
      chk("dim duty", 1'b1, lo_d == 2 * BH / DP * DO);
      pulse(FC);
      chk("clear refused", 1'b1, fof);
      cause = 4'h0;
      pulse(CC);
      pulse(FC);
      cyc(5);
      chk("flag released", 1'b0, fof);
      chk("static released", 1'b1, st_n);
    end
  endtask
  task t_watchdog;
    integer s;
    for (s = 0; s < 2; s++)
    begin
      sel = s == 1;
      pulse(EV);
      chk("restart pulse", 1'b1, rrq);
      cyc(3);
      chk("one strike", s == 0, fof);
      chk("strike flag", 1'b1, wdf);
      pulse(EV);
      cyc(3);
      chk("two strikes", 1'b1, fof);
      pulse(FC);
      chk("held by watchdog", 1'b1, fof);
      if (s == 0)
      begin
        pulse(WC);
        pulse(OK);
      end
      else
      begin
        pulse(OK);
        pulse(FC);
        chk("held until flags clear", 1'b1, fof);
        pulse(WC);
      end
      chk("flags cleared", 1'b0, wdf);
      pulse(FC);
      cyc(5);
      chk("watchdog released", 1'b0, fof);
    end
  endtask
  // Heartbeat loss, refused clear, recovery, then disabled and off-mode runs
  task t_heartbeat;
    dis = 1'b0;
    wait_hb(1'b1, HW + 300);
    cyc(3);
    chk("static on loss", 1'b0, st_n);
    chk("dim on loss", 1'b0, dm_n);
    chk("blink free", 1'b1, bl_n);
    // A short spike must not count as the rise that unlocks the clear
    glitch = 1'b1;
    cyc(20);
    glitch = 1'b0;
    cyc(100);
    pulse(HC);
    chk("flag kept", 1'b1, hbf);
    hb_run = 1'b1;
    cyc(400);
    chk("flag until clear", 1'b1, hbf);
    pulse(HC);
    chk("flag cleared", 1'b0, hbf);
    cyc(3 * HW);
    chk("heartbeat ok", 1'b0, hbf);
    hb_run = 1'b0;
    dis = 1'b1;
    cyc(2 * HW);
    chk("monitor off", 1'b0, hbf);
    dis = 1'b0;
    mode = `MODE_INIT;
    cyc(2 * HW);
    chk("normal only", 1'b0, hbf);
  endtask
  initial
  begin
    cyc(5);
    reset_n = 1'b1;
    chk("flag at reset", 1'b0, fof);
    chk("static idle", 1'b1, st_n);
    t_pullups;
    t_causes;
    t_watchdog;
    test_in = 1'b1;
    cyc(TF - 3);
    chk("test filter", 1'b0, tsel);
    cyc(8);
    chk("test select", 1'b1, tsel);
    t_heartbeat;
    summarize;
  end
endmodule
